// ### phy_mgmt_pkg.sv
// Operation
// - Isolate bit disconnects internal MII both directions
// - Writing restart bit pulses negotiation restart, self-clears
// - Duplex bit selects half/full when negotiation off
// - Duplex bit reads one while negotiation on
// - Loopback makes duplex bit irrelevant
// - Collision test bit unused, resets one, writable
// - 100 Mb abilities read one unless strap
// - 10 Mb ability bits read one
// - Preamble suppression unsupported; full preamble required
// - Negotiation complete bit follows completion, resets zero
// - Remote fault status bit reflects detection
// - Negotiation ability bit reads one
// - Link status latches low until read
// - Jabber latches high, 10 Mb only
// - Extended capability bit reads one
// - Identifier registers return fixed values
// - Advertised next page bit is zero
// - Advertised remote fault writable, resets zero
// - Technology field writable, resets 00101111
// - Selector field fixed 00001
// - Registers reached through management frames
// - Latched bits hold until register read
`default_nettype none
package phy_mgmt_pkg;
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h01;
  localparam logic [4:0] OFS_IDENT_UPPER = 5'h02;
  localparam logic [4:0] OFS_IDENT_LOWER = 5'h03;
  localparam logic [4:0] OFS_ADVERT = 5'h04;

  localparam int CTL_ISOLATE = 10;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COLTEST = 7;
  localparam logic CTL_ISOLATE_RST = 1'b0;
  localparam logic CTL_DUPLEX_RST = 1'b0;
  localparam logic CTL_COLTEST_RST = 1'b1;

  localparam int STS_100FD = 14;
  localparam int STS_100HD = 13;
  localparam int STS_10FD = 12;
  localparam int STS_10HD = 11;
  localparam int STS_PRE_SUPP = 6;
  localparam int STS_AN_DONE = 5;
  localparam int STS_RFAULT = 4;
  localparam int STS_AN_ABLE = 3;
  localparam int STS_LINK = 2;
  localparam int STS_JABBER = 1;
  localparam int STS_EXT_CAP = 0;

  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_RFAULT = 13;
  localparam int ADV_TECH_LSB = 5;
  localparam int ADV_TECH_W = 8;
  localparam int ADV_SEL_W = 5;
  localparam logic ADV_RFAULT_RST = 1'b0;
  localparam logic [7:0] ADV_TECH_RST = 8'h2F;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;

  localparam int PREAMBLE_BITS = 32;
  localparam int HDR_BITS = 14;
  localparam int DATA_BITS = 16;
  localparam logic [1:0] FRAME_START = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;

  typedef enum {ST_PREAMBLE, ST_HEADER, ST_TURN, ST_DATA} frame_state_t;
endpackage
`default_nettype wire

// ### latch_flag_cell.sv
`timescale 1ns/1ns
`default_nettype none
module latch_flag_cell
  import phy_mgmt_pkg::*;
#(
  parameter bit LATCH_HIGH = 1'b1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic event_now,
  input wire logic read_clear,
  output logic flag
);
  logic held_reg;
  logic held_next;
  logic seen;

  // Event in the read cycle survives: it reloads the hold
  assign seen = held_reg | event_now;
  assign held_next = read_clear ? event_now : seen;
  assign flag = LATCH_HIGH ? seen : ~seen;

  // Held event at reset so a latch-low flag starts low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      held_reg <= ~LATCH_HIGH;
    end else if (ce) begin
      held_reg <= held_next;
    end
  end
endmodule // latch_flag_cell
`default_nettype wire

// ### phy_mgmt_control_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_control_status_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter logic [15:0] IDENT_UPPER = 16'h1234, // Arbitrary value
  parameter logic [15:0] IDENT_LOWER = 16'h5670 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic strap_disable_100mb,
  input wire logic autoneg_enable,
  input wire logic loopback_active,
  input wire logic speed_is_100,
  input wire logic link_ok,
  input wire logic jabber_seen,
  input wire logic autoneg_done,
  input wire logic remote_fault_seen,
  output logic mii_isolate,
  output logic autoneg_restart,
  output logic duplex_full,
  output logic [15:0] adv_page
);
  frame_state_t state_reg;
  logic mdc_prev_reg;
  logic [5:0] pre_cnt_reg;
  logic [4:0] bit_cnt_reg;
  logic [13:0] hdr_reg;
  logic [15:0] shift_reg;
  logic is_read_reg;
  logic mdio_out_reg;
  logic mdio_oe_reg;
  logic isolate_reg;
  logic restart_reg;
  logic duplex_reg;
  logic coltest_reg;
  logic adv_rfault_reg;
  logic [7:0] adv_tech_reg;
  logic strap_taken_reg;
  logic strap_reg;

  wire mdc_rise;
  wire [13:0] hdr_full;
  wire hdr_ok;
  wire [4:0] hdr_reg_addr;
  wire hdr_is_read;
  wire read_status;
  wire write_commit;
  wire [15:0] wdata;
  wire [4:0] wr_addr;
  wire link_flag;
  wire jabber_flag;
  wire [15:0] control_view;
  wire [15:0] status_view;
  wire [15:0] advert_view;
  wire [15:0] read_value;

  function automatic logic [15:0] reg_select(input logic [4:0] addr,
      input logic [15:0] ctl, input logic [15:0] sts, input logic [15:0] adv);
    case (addr)
      OFS_CONTROL: reg_select = ctl;
      OFS_STATUS: reg_select = sts;
      OFS_IDENT_UPPER: reg_select = IDENT_UPPER;
      OFS_IDENT_LOWER: reg_select = IDENT_LOWER;
      OFS_ADVERT: reg_select = adv;
      default: reg_select = 16'h0000;
    endcase
  endfunction

  // MDC is a plain sampled input; frames are decoded on its rising edge
  assign mdc_rise = mdc & ~mdc_prev_reg;
  assign hdr_full = {hdr_reg[12:0], mdio_in};
  assign hdr_reg_addr = hdr_full[4:0];
  assign hdr_is_read = hdr_full[11:10] == OP_READ;
  assign hdr_ok = hdr_full[13:12] == FRAME_START && hdr_full[9:5] == PHY_ADDR &&
      (hdr_is_read || hdr_full[11:10] == OP_WRITE);
  assign read_status = mdc_rise && state_reg == ST_HEADER &&
      bit_cnt_reg == 5'(HDR_BITS - 1) && hdr_ok && hdr_is_read &&
      hdr_reg_addr == OFS_STATUS;
  assign write_commit = mdc_rise && state_reg == ST_DATA && !is_read_reg &&
      bit_cnt_reg == 5'(DATA_BITS - 1);
  assign wdata = {shift_reg[14:0], mdio_in};
  assign wr_addr = hdr_reg[4:0];

  latch_flag_cell #(.LATCH_HIGH(1'b0)) link_cell (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .event_now(~link_ok),
    .read_clear(read_status),
    .flag(link_flag)
  );

  latch_flag_cell #(.LATCH_HIGH(1'b1)) jabber_cell (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .event_now(jabber_seen & ~speed_is_100),
    .read_clear(read_status),
    .flag(jabber_flag)
  );

  assign control_view = {5'h00, isolate_reg, 1'b0,
      autoneg_enable | duplex_reg, coltest_reg, 7'h00};
  assign status_view = {1'b0, ~strap_reg, ~strap_reg, 1'b1, 1'b1, 4'h0,
      1'b0, autoneg_done, remote_fault_seen, 1'b1,
      link_flag, jabber_flag, 1'b1};
  assign advert_view = {1'b0, 1'b0, adv_rfault_reg, adv_tech_reg, ADV_SELECTOR};
  assign read_value = reg_select(hdr_reg_addr, control_view, status_view, advert_view);

  assign mdio_out = mdio_out_reg;
  assign mdio_oe = mdio_oe_reg;
  assign mii_isolate = isolate_reg;
  assign autoneg_restart = restart_reg;
  // Loopback runs full duplex whatever the bit holds
  assign duplex_full = loopback_active | autoneg_enable | duplex_reg;
  assign adv_page = advert_view;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_taken_reg <= 1'b0;
      strap_reg <= 1'b0;
    end else if (ce && !strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_reg <= strap_disable_100mb;
    end
  end

  // Frame engine; a frame without a full preamble is never decoded
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mdc_prev_reg <= 1'b0;
      state_reg <= ST_PREAMBLE;
      pre_cnt_reg <= 6'h00;
      bit_cnt_reg <= 5'h00;
      hdr_reg <= 14'h0000;
      shift_reg <= 16'h0000;
      is_read_reg <= 1'b0;
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
    end else if (ce) begin
      mdc_prev_reg <= mdc;
      if (mdc_rise) begin
        case (state_reg)
          ST_PREAMBLE: begin
            if (mdio_in) begin
              if (pre_cnt_reg != 6'(PREAMBLE_BITS)) begin
                pre_cnt_reg <= pre_cnt_reg + 6'h01;
              end
            end else if (pre_cnt_reg == 6'(PREAMBLE_BITS)) begin
              state_reg <= ST_HEADER;
              hdr_reg <= 14'h0000;
              bit_cnt_reg <= 5'h01;
            end else begin
              pre_cnt_reg <= 6'h00;
            end
          end
          ST_HEADER: begin
            hdr_reg <= hdr_full;
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(HDR_BITS - 1)) begin
              bit_cnt_reg <= 5'h00;
              pre_cnt_reg <= 6'h00;
              is_read_reg <= hdr_is_read;
              shift_reg <= read_value;
              state_reg <= hdr_ok ? ST_TURN : ST_PREAMBLE;
            end
          end
          ST_TURN: begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h00) begin
              mdio_oe_reg <= is_read_reg;
              mdio_out_reg <= 1'b0;
            end else begin
              bit_cnt_reg <= 5'h00;
              state_reg <= ST_DATA;
              if (is_read_reg) begin
                mdio_out_reg <= shift_reg[15];
                shift_reg <= {shift_reg[14:0], 1'b0};
              end
            end
          end
          ST_DATA: begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(DATA_BITS - 1)) begin
              mdio_oe_reg <= 1'b0;
              mdio_out_reg <= 1'b0;
              bit_cnt_reg <= 5'h00;
              state_reg <= ST_PREAMBLE;
            end else if (is_read_reg) begin
              mdio_out_reg <= shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'b0};
            end else begin
              shift_reg <= wdata;
            end
          end
          default: begin
            state_reg <= ST_PREAMBLE;
          end
        endcase
      end
    end
  end

  // Register writes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      isolate_reg <= CTL_ISOLATE_RST;
      restart_reg <= 1'b0;
      duplex_reg <= CTL_DUPLEX_RST;
      coltest_reg <= CTL_COLTEST_RST;
      adv_rfault_reg <= ADV_RFAULT_RST;
      adv_tech_reg <= ADV_TECH_RST;
    end else if (ce) begin
      restart_reg <= write_commit && wr_addr == OFS_CONTROL && wdata[CTL_RESTART];
      if (write_commit && wr_addr == OFS_CONTROL) begin
        isolate_reg <= wdata[CTL_ISOLATE];
        coltest_reg <= wdata[CTL_COLTEST];
        if (!autoneg_enable) begin
          duplex_reg <= wdata[CTL_DUPLEX];
        end
      end
      if (write_commit && wr_addr == OFS_ADVERT) begin
        adv_rfault_reg <= wdata[ADV_RFAULT];
        adv_tech_reg <= wdata[ADV_TECH_LSB +: ADV_TECH_W];
      end
    end
  end

  restart_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      restart_reg |=> !restart_reg || $past(write_commit))
    else $error("restart bit did not clear itself");

  restart_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && write_commit && wr_addr == OFS_CONTROL && wdata[CTL_RESTART] |=>
      autoneg_restart)
    else $error("restart write gave no pulse");

  isolate_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && write_commit && wr_addr == OFS_CONTROL |=>
      mii_isolate == $past(wdata[CTL_ISOLATE]))
    else $error("isolate bit not written");

  duplex_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && write_commit && wr_addr == OFS_CONTROL && !autoneg_enable |=>
      duplex_reg == $past(wdata[CTL_DUPLEX]))
    else $error("duplex bit not written");

  duplex_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && write_commit && wr_addr == OFS_CONTROL && autoneg_enable |=>
      $stable(duplex_reg))
    else $error("duplex written under negotiation");

  coltest_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && write_commit && wr_addr == OFS_CONTROL |=>
      coltest_reg == $past(wdata[CTL_COLTEST]))
    else $error("collision test bit not written");

  advert_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && write_commit && wr_addr == OFS_ADVERT |=>
      adv_page[ADV_RFAULT] == $past(wdata[ADV_RFAULT]) &&
      adv_page[ADV_TECH_LSB +: ADV_TECH_W] == $past(wdata[ADV_TECH_LSB +: ADV_TECH_W]))
    else $error("advertisement field not written");

  duplex_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      autoneg_enable |-> control_view[CTL_DUPLEX])
    else $error("duplex bit not one under negotiation");

  loopback_duplex_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      loopback_active |-> duplex_full)
    else $error("duplex depends on bit in loopback");

  fixed_bits_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      status_view[STS_10FD] && status_view[STS_10HD] && status_view[STS_AN_ABLE] &&
      status_view[STS_EXT_CAP] && !status_view[STS_PRE_SUPP])
    else $error("fixed status bit wrong");

  strap_ability_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      strap_taken_reg |-> status_view[STS_100FD] == !strap_reg &&
      status_view[STS_100HD] == !strap_reg)
    else $error("100 Mb ability ignores strap");

  strap_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(strap_taken_reg) |-> strap_reg == $past(strap_disable_100mb))
    else $error("strap not captured after reset");

  link_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && !link_ok && !read_status |=> !link_flag)
    else $error("link loss not held low");

  jabber_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ce && jabber_seen && !speed_is_100 |=> jabber_flag)
    else $error("jabber not held high");

  advert_fixed_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      adv_page[ADV_NEXT_PAGE] == 1'b0 && adv_page[ADV_SEL_W-1:0] == ADV_SELECTOR)
    else $error("fixed advertisement bits wrong");

  read_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(mdio_oe) |-> !mdio_out && state_reg == ST_TURN)
    else $error("read turnaround drive wrong");

  preamble_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      state_reg == ST_HEADER && $past(state_reg) == ST_PREAMBLE |->
      $past(pre_cnt_reg) == 6'(PREAMBLE_BITS))
    else $error("frame started without full preamble");
endmodule // phy_mgmt_control_status_regs
`default_nettype wire

// ### mdio_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module mdio_ctrl_model
  import phy_mgmt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic mdio_line,
  output logic mdc,
  output logic drv_en,
  output logic drv_dat
);
  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_dat = 1'b1;
  end
  // Three clk_sys low, two high per MDC bit; the device needs at least one of each
  task automatic xfer(input int pre, input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] body;
    body = {FRAME_START, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < pre + 32; i++) begin
      @(negedge clk_sys);
      drv_en = (i < pre + 14) || (op == OP_WRITE);
      drv_dat = (i < pre) ? 1'b1 : body[31 - (i - pre)];
      repeat (2) @(negedge clk_sys);
      if (i >= pre + 16) rd = {rd[14:0], mdio_line};
      mdc = 1'b1;
      repeat (2) @(negedge clk_sys);
      mdc = 1'b0;
    end
    @(negedge clk_sys);
    drv_en = 1'b0;
  endtask
endmodule // mdio_ctrl_model
`default_nettype wire

// ### phy_mgmt_control_status_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_control_status_regs_tb;
  import phy_mgmt_pkg::*;
  localparam logic [15:0] ID_HI = 16'hA5C3; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'h3C5A; // Arbitrary value
  logic clk_sys, resetn, strap, an_en, lpbk, spd100, link, jab, an_done, rflt;
  logic mdio_out, mdio_oe, mdc, drv_en, drv_dat, isol, restart, dup, ce;
  logic [15:0] adv_page, rd;
  wire logic mdio_line;
  int err_total, check_count, restarts;
  // Released line floats to the pull-up level
  assign mdio_line = mdio_oe ? mdio_out : (drv_en ? drv_dat : 1'b1);

  phy_mgmt_control_status_regs #(.PHY_ADDR(5'h01), .IDENT_UPPER(ID_HI),
      .IDENT_LOWER(ID_LO)) uut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
      .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .strap_disable_100mb(strap), .autoneg_enable(an_en), .loopback_active(lpbk),
      .speed_is_100(spd100), .link_ok(link), .jabber_seen(jab), .autoneg_done(an_done),
      .remote_fault_seen(rflt), .mii_isolate(isol), .autoneg_restart(restart),
      .duplex_full(dup), .adv_page(adv_page));
  mdio_ctrl_model mst (.clk_sys(clk_sys), .mdio_line(mdio_line), .mdc(mdc),
      .drv_en(drv_en), .drv_dat(drv_dat));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (restart === 1'b1) restarts++;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rdr(input logic [4:0] ra);
    mst.xfer(32, OP_READ, 5'h01, ra, 16'h0000, rd);
  endtask
  task automatic wrr(input logic [4:0] ra, input logic [15:0] d);
    mst.xfer(32, OP_WRITE, 5'h01, ra, d, rd);
  endtask
  task automatic do_reset(input logic s);
    @(negedge clk_sys);
    resetn = 1'b0;
    strap = s;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic t_reset_values;
    rdr(OFS_CONTROL); check("control", rd, 16'h0080);
    rdr(OFS_ADVERT); check("advert", rd, 16'h05E1);
    check("adv_page", adv_page, 16'h05E1);
    rdr(OFS_IDENT_UPPER); check("ident hi", rd, ID_HI);
    rdr(OFS_IDENT_LOWER); check("ident lo", rd, ID_LO);
  endtask
  task automatic t_strap;
    do_reset(1'b1);
    rdr(OFS_STATUS); check("status strap", rd, 16'h1809);
    do_reset(1'b0);
    rdr(OFS_STATUS); check("status first", rd, 16'h7809);
    rdr(OFS_STATUS); check("status again", rd, 16'h780D);
  endtask
  task automatic t_latch;
    an_done = 1'b1;
    rflt = 1'b1;
    link = 1'b0;
    jab = 1'b1;
    repeat (3) @(negedge clk_sys);
    link = 1'b1;
    jab = 1'b0;
    rdr(OFS_STATUS); check("status latched", rd, 16'h783B);
    rdr(OFS_STATUS); check("status follow", rd, 16'h783D);
    spd100 = 1'b1;
    jab = 1'b1;
    repeat (3) @(negedge clk_sys);
    jab = 1'b0;
    rdr(OFS_STATUS); check("status 100 jabber", rd, 16'h783D);
  endtask
  // Link loss while frozen must leave no latched trace
  task automatic t_freeze;
    ce = 1'b0;
    link = 1'b0;
    repeat (3) @(negedge clk_sys);
    link = 1'b1;
    ce = 1'b1;
    rdr(OFS_STATUS); check("status frozen", rd, 16'h783D);
  endtask
  task automatic t_control;
    int n;
    n = restarts;
    wrr(OFS_CONTROL, 16'hFFFF);
    rdr(OFS_CONTROL); check("control set", rd, 16'h0580);
    check("isolate", {15'h0, isol}, 16'h0001);
    check("restart", 16'(restarts - n), 16'h0001);
    check("duplex full", {15'h0, dup}, 16'h0001);
    wrr(OFS_CONTROL, 16'h0000);
    rdr(OFS_CONTROL); check("control clear", rd, 16'h0000);
    check("isolate off", {15'h0, isol}, 16'h0000);
    check("no restart", 16'(restarts - n), 16'h0001);
    check("duplex half", {15'h0, dup}, 16'h0000);
    lpbk = 1'b1;
    @(negedge clk_sys);
    check("loopback duplex", {15'h0, dup}, 16'h0001);
    lpbk = 1'b0;
    an_en = 1'b1;
    rdr(OFS_CONTROL); check("control an", rd, 16'h0100);
    check("an duplex", {15'h0, dup}, 16'h0001);
    wrr(OFS_CONTROL, 16'h0100);
    an_en = 1'b0;
    rdr(OFS_CONTROL); check("duplex dropped", rd, 16'h0000);
  endtask
  task automatic t_advert;
    wrr(OFS_ADVERT, 16'hFFFF);
    rdr(OFS_ADVERT); check("advert set", rd, 16'h3FE1);
    check("adv_page set", adv_page, 16'h3FE1);
    wrr(OFS_ADVERT, 16'h0000);
    rdr(OFS_ADVERT); check("advert clear", rd, 16'h0001);
  endtask
  task automatic t_refuse;
    rdr(5'h1F); check("unmapped", rd, 16'h0000);
    // Ones clocked after a refused header count as preamble, so go short first
    mst.xfer(31, OP_WRITE, 5'h01, OFS_ADVERT, 16'hFFFF, rd);
    rdr(OFS_ADVERT); check("short preamble", rd, 16'h0001);
    mst.xfer(32, OP_READ, 5'h02, OFS_IDENT_UPPER, 16'h0000, rd);
    check("other phy", rd, 16'hFFFF);
  endtask

  initial begin
    {resetn, strap, an_en, lpbk, spd100, link, jab, an_done, rflt} = 9'h008;
    ce = 1'b1;
    err_total = 0;
    check_count = 0;
    restarts = 0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_reset_values;
    t_strap;
    t_latch;
    t_freeze;
    t_control;
    t_advert;
    t_refuse;
    report_and_stop;
  end
  // Whole run needs about 1 ms of frames
  initial begin
    #5000000;
    err_total++;
    report_and_stop;
  end
endmodule // phy_mgmt_control_status_regs_tb
`default_nettype wire
